// ---- erff_pkg.sv ----
// Operation
// - With the type-field option on, frames whose type field is a real type pass the encapsulation check.
// - With the SNAP or LLC option on, frames carrying that header pass the encapsulation check.
// - With no encapsulation option on, every frame passes the encapsulation check.
// - Up to eight stacked MPLS and VLAN levels are matched, each with its own settings.
// - The pattern criterion compares a 32-bit value with four frame bytes at the pattern offset.
// - One pattern offset serves all eight rows and counts only in enabled rows using the pattern.
// - The pattern offset counts bytes from the first destination address byte.
// - An MPLS level matches label and TTL, optionally bottom-of-stack and experimental bits.
// - A VLAN level matches priority and VLAN id, optionally the CFI bit.
// - Bit rate and rate difference use one-second windows, from the external reference if valid.
// - The accumulated difference sums continuously and clears on measurement start.
// - Separate flags show frames present, MPLS label seen and VLAN tag seen.
// - GPS availability stays off for 30 seconds after the GPS signal appears.
// - A frame passes the rows when all enabled criteria of one enabled row match.
// - With a mask enabled only bits whose mask bit is one are compared.
package erff_pkg;
   localparam int NROWS = 8;
   localparam int NLVL = 8;
   localparam int FIFO_W = 16;
   localparam int FIFO_D = 8;
   // Header layout, byte positions from the first destination address byte
   localparam logic [15:0] TYPE_POS = 16'h000c;
   localparam logic [15:0] TAG_STEP = 16'h0004;
   localparam logic [15:0] MPLS_OFS = 16'h0002;
   localparam logic [15:0] LAST_OF4 = 16'h0003;
   localparam logic [15:0] LAST_OF2 = 16'h0001;
   localparam logic [15:0] TYPE_VLAN = 16'h8100;
   localparam logic [15:0] TYPE_MPLS_UC = 16'h8847;
   localparam logic [15:0] TYPE_MPLS_MC = 16'h8848;
   localparam logic [15:0] TYPE_MIN = 16'h0600;
   localparam logic [15:0] SNAP_SAPS = 16'haaaa;
   // Field positions inside a VLAN tag control word and an MPLS entry
   localparam int VLAN_CFI_BIT = 12;
   localparam int MPLS_BOS_BIT = 8;
   localparam int MPLS_EXP_LO = 9;
   localparam int MPLS_EXP_HI = 11;
   localparam logic [3:0] LVL_LAST = 4'h7;
   localparam logic [3:0] LVL_FULL = 4'h8;
   // Timing
   localparam longint CLK_HZ = 10_000_000;
   localparam longint REF_HZ = 10_000_000;
   localparam longint WINDOW_S = 1;
   localparam longint WINDOW_CYC = CLK_HZ * WINDOW_S;
   localparam longint WINDOW_REF = REF_HZ * WINDOW_S;
   localparam logic [5:0] GPS_SYNC_S = 6'h1e;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Receive parser states
   typedef enum logic [1:0] {
      ERFF_IDLE = 2'b00,
      ERFF_RECV = 2'b01,
      ERFF_PUSH = 2'b11
   } erff_state_e;
endpackage

// ---- erff_filter.sv ----
`timescale 1ns/100ps
//------------------------------------------------------------
// Verdict FIFO
//------------------------------------------------------------
module erff_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_r];
   assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_r <= push ? AW'((wr_r + 1'b1) % D) : wr_r;
         rd_r <= pop ? AW'((rd_r + 1'b1) % D) : rd_r;
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != (AW+1)'(D));
         out_valid <= (cnt_nxt != '0);
      end
   end
endmodule // erff_fifo

//------------------------------------------------------------
// Receive frame filter and status
//------------------------------------------------------------
module erff_filter
   import erff_pkg::*;
#(
   parameter longint WIN_CYC = erff_pkg::WINDOW_CYC,
   parameter longint WIN_REF = erff_pkg::WINDOW_REF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Received byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_sof,
   input wire logic rx_eof,
   output logic rx_ready,
   // Analysis path: length of each passing frame
   output logic ana_valid,
   output logic [erff_pkg::FIFO_W-1:0] ana_len,
   input wire logic ana_ready,
   // Global filter settings
   input wire logic filt_en,
   input wire logic enc_eth,
   input wire logic enc_snap,
   input wire logic enc_llc,
   input wire logic [15:0] pat_off,
   // Row settings
   input wire logic [erff_pkg::NROWS-1:0] row_en,
   input wire logic [erff_pkg::NROWS-1:0] row_pat_en,
   input wire logic [erff_pkg::NROWS-1:0] row_pat_mask_en,
   input wire logic [erff_pkg::NROWS*32-1:0] row_pat_val,
   input wire logic [erff_pkg::NROWS*32-1:0] row_pat_mask,
   input wire logic [erff_pkg::NROWS*erff_pkg::NLVL-1:0] row_vlan_sel,
   input wire logic [erff_pkg::NROWS*erff_pkg::NLVL-1:0] row_mpls_sel,
   // Per-level settings
   input wire logic [erff_pkg::NLVL*16-1:0] lvl_vlan_val,
   input wire logic [erff_pkg::NLVL*16-1:0] lvl_vlan_mask,
   input wire logic [erff_pkg::NLVL-1:0] lvl_vlan_mask_en,
   input wire logic [erff_pkg::NLVL-1:0] lvl_vlan_cfi_en,
   input wire logic [erff_pkg::NLVL*32-1:0] lvl_mpls_val,
   input wire logic [erff_pkg::NLVL*32-1:0] lvl_mpls_mask,
   input wire logic [erff_pkg::NLVL-1:0] lvl_mpls_mask_en,
   input wire logic [erff_pkg::NLVL-1:0] lvl_mpls_bos_en,
   input wire logic [erff_pkg::NLVL-1:0] lvl_mpls_exp_en,
   // Rate measurement
   input wire logic meas_start,
   input wire logic [31:0] nominal_rate,
   input wire logic ext_ref_valid,
   input wire logic ext_ref_clk,
   input wire logic gps_present,
   output logic [31:0] bit_rate,
   output logic [31:0] rate_diff,
   output logic [47:0] acc_diff,
   output logic window_tick,
   output logic gps_avail,
   // Receive status flags
   output logic frame_present,
   output logic mpls_seen,
   output logic vlan_seen
);
   import erff_pkg::*;

   //------------------------------------------------------------
   // Settings snapshot
   //------------------------------------------------------------
   logic s_filt, s_eth, s_snap, s_llc;
   logic [15:0] s_poff;
   logic [NROWS-1:0] s_row_en, s_pat_en, s_pat_men;
   logic [NROWS*32-1:0] s_pat_val, s_pat_mask;
   logic [NROWS*NLVL-1:0] s_vsel, s_msel;
   logic [NLVL*16-1:0] s_vval, s_vmask;
   logic [NLVL-1:0] s_vmen, s_vcfi, s_mmen, s_mbos, s_mexp;
   logic [NLVL*32-1:0] s_mval, s_mmask;
   logic take;
   logic first;

   assign take = rx_valid && rx_ready;
   assign first = take && rx_sof;

   always_ff @(posedge clk) begin
      if (first) begin
         s_filt <= filt_en;
         s_eth <= enc_eth;
         s_snap <= enc_snap;
         s_llc <= enc_llc;
         s_poff <= pat_off;
         s_row_en <= row_en;
         s_pat_en <= row_pat_en;
         s_pat_men <= row_pat_mask_en;
         s_pat_val <= row_pat_val;
         s_pat_mask <= row_pat_mask;
         s_vsel <= row_vlan_sel;
         s_msel <= row_mpls_sel;
         s_vval <= lvl_vlan_val;
         s_vmask <= lvl_vlan_mask;
         s_vmen <= lvl_vlan_mask_en;
         s_vcfi <= lvl_vlan_cfi_en;
         s_mval <= lvl_mpls_val;
         s_mmask <= lvl_mpls_mask;
         s_mmen <= lvl_mpls_mask_en;
         s_mbos <= lvl_mpls_bos_en;
         s_mexp <= lvl_mpls_exp_en;
      end
   end

   //------------------------------------------------------------
   // Header parser
   //------------------------------------------------------------
   erff_state_e state_r;
   logic [15:0] cnt_r, idx, tp_r, mpos_r, len_r;
   logic [31:0] sh_r, sh_nxt, pat_r;
   logic [15:0] tag_r [NLVL];
   logic [31:0] lbl_r [NLVL];
   logic [3:0] nv_r, nm_r;
   logic tags_done_r, in_mpls_r, is_type_r, is_snap_r, is_llc_r, pat_ok_r;
   logic fifo_ready, push;

   assign idx = rx_sof ? 16'h0000 : cnt_r;
   assign sh_nxt = {sh_r[23:0], rx_data};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ERFF_IDLE;
         rx_ready <= 1'b0;
      end else begin
         case (state_r)
            ERFF_IDLE, ERFF_RECV: begin
               rx_ready <= 1'b1;
               if (take && rx_eof) begin
                  state_r <= ERFF_PUSH;
                  rx_ready <= 1'b0;
               end else if (first) begin
                  state_r <= ERFF_RECV;
               end
            end
            ERFF_PUSH: begin
               if (fifo_ready || !push) begin
                  state_r <= ERFF_IDLE;
                  rx_ready <= 1'b1;
               end
            end
            default: begin
               state_r <= ERFF_IDLE;
               rx_ready <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= '0;
         len_r <= '0;
         sh_r <= '0;
         tp_r <= TYPE_POS;
         mpos_r <= '0;
         nv_r <= '0;
         nm_r <= '0;
         tags_done_r <= 1'b0;
         in_mpls_r <= 1'b0;
         is_type_r <= 1'b0;
         is_snap_r <= 1'b0;
         is_llc_r <= 1'b0;
         pat_ok_r <= 1'b0;
         pat_r <= '0;
      end else if (take) begin
         cnt_r <= idx + 1'b1;
         len_r <= idx + 1'b1;
         sh_r <= sh_nxt;
         if (rx_sof) begin
            tp_r <= TYPE_POS;
            nv_r <= '0;
            nm_r <= '0;
            tags_done_r <= 1'b0;
            in_mpls_r <= 1'b0;
            is_type_r <= 1'b0;
            is_snap_r <= 1'b0;
            is_llc_r <= 1'b0;
            pat_ok_r <= 1'b0;
         end
         if (!tags_done_r && idx == tp_r + LAST_OF4 && sh_nxt[31:16] == TYPE_VLAN
               && nv_r != LVL_FULL) begin
            tag_r[nv_r[2:0]] <= sh_nxt[15:0];
            nv_r <= nv_r + 1'b1;
            tp_r <= tp_r + TAG_STEP;
         end else if (!tags_done_r && idx == tp_r + LAST_OF2 && sh_nxt[15:0] != TYPE_VLAN) begin
            tags_done_r <= 1'b1;
            is_type_r <= sh_nxt[15:0] >= TYPE_MIN;
            in_mpls_r <= sh_nxt[15:0] == TYPE_MPLS_UC || sh_nxt[15:0] == TYPE_MPLS_MC;
            mpos_r <= tp_r + MPLS_OFS;
         end
         if (tags_done_r && !is_type_r && idx == tp_r + LAST_OF4) begin
            is_snap_r <= sh_nxt[15:0] == SNAP_SAPS;
            is_llc_r <= sh_nxt[15:0] != SNAP_SAPS;
         end
         if (in_mpls_r && idx == mpos_r + LAST_OF4) begin
            lbl_r[nm_r[2:0]] <= sh_nxt;
            nm_r <= nm_r + 1'b1;
            mpos_r <= mpos_r + TAG_STEP;
            if (sh_nxt[MPLS_BOS_BIT] || nm_r == {1'b0, LVL_LAST[2:0]}) begin
               in_mpls_r <= 1'b0;
            end
         end
         if (idx == s_poff + LAST_OF4 && !(rx_sof && pat_off != '0)) begin
            pat_r <= sh_nxt;
            pat_ok_r <= 1'b1;
         end
      end
   end

   //------------------------------------------------------------
   // Level, row and encapsulation matching
   //------------------------------------------------------------
   logic [NLVL-1:0] vlan_hit, mpls_hit;
   logic [NROWS-1:0] row_hit;
   logic enc_ok, rows_ok;

   for (genvar l = 0; l < NLVL; l++) begin : g_lvl
      logic [15:0] vcare;
      logic [31:0] mcare;
      always_comb begin
         vcare = s_vmen[l] ? s_vmask[l*16 +: 16] : '1;
         vcare[VLAN_CFI_BIT] = vcare[VLAN_CFI_BIT] & s_vcfi[l];
         mcare = s_mmen[l] ? s_mmask[l*32 +: 32] : '1;
         mcare[MPLS_BOS_BIT] = mcare[MPLS_BOS_BIT] & s_mbos[l];
         mcare[MPLS_EXP_HI:MPLS_EXP_LO] = mcare[MPLS_EXP_HI:MPLS_EXP_LO] & {3{s_mexp[l]}};
      end
      assign vlan_hit[l] = (nv_r > 4'(l)) && (((tag_r[l] ^ s_vval[l*16 +: 16]) & vcare) == '0);
      assign mpls_hit[l] = (nm_r > 4'(l)) && (((lbl_r[l] ^ s_mval[l*32 +: 32]) & mcare) == '0);
   end

   for (genvar r = 0; r < NROWS; r++) begin : g_row
      logic [31:0] pcare;
      logic pat_hit;
      assign pcare = s_pat_men[r] ? s_pat_mask[r*32 +: 32] : '1;
      assign pat_hit = pat_ok_r && (((pat_r ^ s_pat_val[r*32 +: 32]) & pcare) == '0);
      assign row_hit[r] = s_row_en[r] && (!s_pat_en[r] || pat_hit)
         && ((s_vsel[r*NLVL +: NLVL] & ~vlan_hit) == '0)
         && ((s_msel[r*NLVL +: NLVL] & ~mpls_hit) == '0);
   end

   assign enc_ok = !(s_eth || s_snap || s_llc)
      || (s_eth && is_type_r)
      || (s_snap && is_snap_r) || (s_llc && is_llc_r);
   assign rows_ok = !s_filt || (row_hit != '0);
   assign push = (state_r == ERFF_PUSH) && enc_ok && rows_ok;

   erff_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_data(len_r),
      .in_ready(fifo_ready),
      .out_valid(ana_valid),
      .out_data(ana_len),
      .out_ready(ana_ready)
   );

   //------------------------------------------------------------
   // One-second windows
   //------------------------------------------------------------
   logic [2:0] ref_v_s, ref_c_s, gps_s;
   logic [31:0] cyc_r, edg_r, bits_r;
   logic ref_edge, tick;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_v_s <= '0;
         ref_c_s <= '0;
         gps_s <= '0;
      end else begin
         ref_v_s <= {ref_v_s[1:0], ext_ref_valid};
         ref_c_s <= {ref_c_s[1:0], ext_ref_clk};
         gps_s <= {gps_s[1:0], gps_present};
      end
   end

   assign ref_edge = ref_c_s[1] && !ref_c_s[2];
   assign tick = ref_v_s[1] ? (ref_edge && edg_r == 32'(WIN_REF - 1))
      : (cyc_r == 32'(WIN_CYC - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cyc_r <= '0;
         edg_r <= '0;
         bits_r <= '0;
         bit_rate <= '0;
         rate_diff <= '0;
         acc_diff <= '0;
         window_tick <= 1'b0;
      end else begin
         window_tick <= tick && !meas_start;
         if (meas_start || tick || ref_v_s[1]) begin
            cyc_r <= '0;
         end else begin
            cyc_r <= cyc_r + 1'b1;
         end
         if (meas_start || tick || !ref_v_s[1]) begin
            edg_r <= '0;
         end else if (ref_edge) begin
            edg_r <= edg_r + 1'b1;
         end
         if (meas_start || tick) begin
            bits_r <= take ? 32'(BYTE_BITS) : '0;
         end else if (take) begin
            bits_r <= bits_r + 32'(BYTE_BITS);
         end
         if (meas_start) begin
            acc_diff <= '0;
         end else if (tick) begin
            bit_rate <= bits_r;
            rate_diff <= bits_r - nominal_rate;
            acc_diff <= acc_diff + 48'(signed'(33'(bits_r) - 33'(nominal_rate)));
         end
      end
   end

   //------------------------------------------------------------
   // GPS availability and status flags
   //------------------------------------------------------------
   logic [5:0] gps_cnt_r;
   logic seen_f, seen_m, seen_v;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gps_cnt_r <= '0;
         gps_avail <= 1'b0;
      end else if (!gps_s[1]) begin
         gps_cnt_r <= '0;
         gps_avail <= 1'b0;
      end else if (tick && gps_cnt_r != GPS_SYNC_S) begin
         gps_cnt_r <= gps_cnt_r + 1'b1;
         gps_avail <= (gps_cnt_r + 1'b1) == GPS_SYNC_S;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         seen_f <= 1'b0;
         seen_m <= 1'b0;
         seen_v <= 1'b0;
         frame_present <= 1'b0;
         mpls_seen <= 1'b0;
         vlan_seen <= 1'b0;
      end else begin
         if (state_r == ERFF_PUSH) begin
            frame_present <= 1'b1;
            mpls_seen <= mpls_seen || nm_r != '0;
            vlan_seen <= vlan_seen || nv_r != '0;
         end else if (tick) begin
            frame_present <= seen_f;
            mpls_seen <= seen_m;
            vlan_seen <= seen_v;
         end
         if (tick) begin
            seen_f <= state_r == ERFF_PUSH;
            seen_m <= state_r == ERFF_PUSH && nm_r != '0;
            seen_v <= state_r == ERFF_PUSH && nv_r != '0;
         end else if (state_r == ERFF_PUSH) begin
            seen_f <= 1'b1;
            seen_m <= seen_m || nm_r != '0;
            seen_v <= seen_v || nv_r != '0;
         end
      end
   end
endmodule // erff_filter

// ---- erff_monitor.sv ----
`timescale 1ns/100ps
// ------
// Port checker
// ------
module erff_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Receive side
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic rx_eof,
   // Analysis side
   input wire logic ana_valid,
   input wire logic [erff_pkg::FIFO_W-1:0] ana_len,
   input wire logic ana_ready,
   // Rate and status
   input wire logic meas_start,
   input wire logic [31:0] nominal_rate,
   input wire logic gps_present,
   input wire logic [31:0] bit_rate,
   input wire logic [31:0] rate_diff,
   input wire logic [47:0] acc_diff,
   input wire logic window_tick,
   input wire logic gps_avail
);
   import erff_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence eof_take;
      rx_valid && rx_ready && rx_eof;
   endsequence
   sequence gps_gone;
      (!gps_present) [*5];
   endsequence
   AST_VERDICT_GAP: assert property (eof_take |=> !rx_ready)
      else $error("byte stream not paused after frame end");
   AST_ANA_FROM_VERDICT: assert property ($rose(ana_valid) |-> !$past(rx_ready))
      else $error("analysis word without a verdict cycle");
   AST_ANA_HOLD: assert property (ana_valid && !ana_ready |=> ana_valid && $stable(ana_len))
      else $error("analysis word changed while stalled");
   AST_TICK_PULSE: assert property (window_tick |=> !window_tick)
      else $error("window tick longer than one cycle");
   AST_RATE_DIFF: assert property (window_tick |-> rate_diff == bit_rate - nominal_rate)
      else $error("rate difference wrong");
   AST_ACC_CLEAR: assert property (meas_start |=> acc_diff == 48'h0)
      else $error("accumulated difference not cleared");
   AST_ACC_SUM: assert property (window_tick && !$past(meas_start) |->
      acc_diff == $past(acc_diff) + {{16{rate_diff[31]}}, rate_diff})
      else $error("accumulated difference not summed");
   AST_GPS_DROP: assert property (gps_gone |-> !gps_avail)
      else $error("gps available without gps signal");
endmodule // erff_monitor

// ---- erff_link_src.sv ----
`timescale 1ns/100ps
// ------
// Link byte source
// ------
module erff_link_src (
   // Clock
   input wire logic clk,
   // Byte stream toward the filter
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_sof,
   output logic rx_eof
);
   logic [7:0] mem [256];
   initial begin
      rx_valid = 1'h0;
      rx_data = 8'h00;
      rx_sof = 1'h0;
      rx_eof = 1'h0;
   end
   // Holds each byte until taken; idle data shows the inverse of the last byte
   task automatic send(input int n);
      int i;
      i = 0;
      while (i < n) begin
         rx_valid <= 1'h1;
         rx_data <= mem[i];
         rx_sof <= (i == 0);
         rx_eof <= (i == n - 1);
         @(posedge clk);
         if (rx_ready === 1'h1) i++;
      end
      rx_valid <= 1'h0;
      rx_sof <= 1'h0;
      rx_eof <= 1'h0;
      rx_data <= ~mem[n-1];
   endtask
endmodule // erff_link_src

// ---- tb_top.sv ----
`timescale 1ns/100ps
bind erff_filter erff_monitor mon (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
   .rx_ready(rx_ready), .rx_eof(rx_eof), .ana_valid(ana_valid), .ana_len(ana_len),
   .ana_ready(ana_ready), .meas_start(meas_start), .nominal_rate(nominal_rate),
   .gps_present(gps_present), .bit_rate(bit_rate), .rate_diff(rate_diff),
   .acc_diff(acc_diff), .window_tick(window_tick), .gps_avail(gps_avail));
// ------
// Testbench
// ------
module tb_top;
   import erff_pkg::*;
   localparam int WIN = 200;
   localparam logic [63:0] HDR [5] = '{64'h0800_1111_1111_1111, 64'h8100_a005_0800_1111,
      64'h8847_1234_5140_4500, 64'h0020_aaaa_0300_0000, 64'h0020_4242_0300_0000};
   typedef struct packed {
      logic [2:0] kind;
      logic [2:0] enc;
      logic filt;
      logic [7:0] ren;
      logic off8;
      logic pass;
   } erff_row_s;
   erff_row_s rows [17];
   logic clk, sys_rst, rx_valid, rx_sof, rx_eof, rx_ready, ana_valid, ana_ready, filt_en;
   logic enc_eth, enc_snap, enc_llc, meas_start, gps_present, window_tick, gps_avail;
   logic frame_present, mpls_seen, vlan_seen;
   logic [7:0] rx_data, row_en;
   logic [15:0] ana_len, pat_off;
   logic [31:0] bit_rate, rate_diff, nominal_rate, e32;
   logic [47:0] acc_diff, ea;
   logic [7:0] pen = 8'h0b, pme = 8'h08, lme = 8'h01, xre = 8'h00;
   logic [255:0] pval = {128'h0, 32'hff08ffff, 32'h0, 32'h0708090a, 32'h0708090a};
   logic [255:0] pmask = {128'h0, 32'h00ff0000, 96'h0}, mval = 256'h12345140;
   logic [255:0] mmask = 256'hffffffff;
   logic [63:0] vsel = 64'h100, msel = 64'h10000;
   logic [127:0] vval = 128'ha005, vmask = 128'hffff;
   logic [15:0] got_q [$];
   int mismatches, n_tests, c;
   erff_link_src src (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof));
   erff_filter #(.WIN_CYC(WIN), .WIN_REF(5)) dut (.clk(clk), .sys_rst(sys_rst),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
      .rx_ready(rx_ready), .ana_valid(ana_valid), .ana_len(ana_len), .ana_ready(ana_ready),
      .filt_en(filt_en), .enc_eth(enc_eth), .enc_snap(enc_snap), .enc_llc(enc_llc),
      .pat_off(pat_off), .row_en(row_en), .row_pat_en(pen), .row_pat_mask_en(pme),
      .row_pat_val(pval), .row_pat_mask(pmask), .row_vlan_sel(vsel), .row_mpls_sel(msel),
      .lvl_vlan_val(vval), .lvl_vlan_mask(vmask), .lvl_vlan_mask_en(lme),
      .lvl_vlan_cfi_en(lme), .lvl_mpls_val(mval), .lvl_mpls_mask(mmask),
      .lvl_mpls_mask_en(lme), .lvl_mpls_bos_en(lme), .lvl_mpls_exp_en(lme),
      .meas_start(meas_start), .nominal_rate(nominal_rate), .ext_ref_valid(xre[0]),
      .ext_ref_clk(xre[1]), .gps_present(gps_present), .bit_rate(bit_rate),
      .rate_diff(rate_diff), .acc_diff(acc_diff), .window_tick(window_tick),
      .gps_avail(gps_avail), .frame_present(frame_present), .mpls_seen(mpls_seen),
      .vlan_seen(vlan_seen));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ana_valid === 1'h1 && ana_ready === 1'h1) got_q.push_back(ana_len);
   end
   // Reference clock, eight clk cycles a period
   always begin
      repeat (4) @(posedge clk);
      xre[1] <= ~xre[1];
   end
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Frame bytes: index as payload, header block at bytes 12 to 19
   task automatic build(input logic [2:0] k, input int n);
      for (int i = 0; i < n; i++) src.mem[i] = (i < 12 || i > 19) ? i[7:0] : HDR[k][8*(19-i)+:8];
   endtask
   task automatic wait_tick();
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (window_tick !== 1'h1 && c < 3 * WIN);
   endtask
   task automatic run_row(input int i);
      int n;
      n = 20 + i;
      @(posedge clk);
      filt_en <= rows[i].filt;
      {enc_eth, enc_snap, enc_llc} <= rows[i].enc;
      row_en <= rows[i].ren;
      pat_off <= rows[i].off8 ? 16'h0008 : 16'h0007;
      build(rows[i].kind, n);
      got_q.delete();
      @(posedge clk);
      src.send(n);
      repeat (6) @(posedge clk);
      cmp(got_q.size(), rows[i].pass);
      if (rows[i].pass) cmp(got_q[0], n);
      if (rows[i].kind == 3'h1) cmp(vlan_seen, 1'h1);
      if (rows[i].kind == 3'h2) cmp(mpls_seen, 1'h1);
      cmp(frame_present, 1'h1);
      $display("row %0d done", i);
   endtask
   initial begin
      sys_rst = 1'h1;
      ana_ready = 1'h1;
      {filt_en, enc_eth, enc_snap, enc_llc, meas_start, gps_present} = 6'h00;
      row_en = 8'h00;
      pat_off = 16'h0007;
      nominal_rate = 32'h64;
      // Kinds: 0 type, 1 tagged, 2 label stack, 3 snap, 4 llc; enc is type, snap, llc
      rows = '{'{3'h0, 3'h0, 1'h0, 8'h00, 1'h0, 1'h1}, '{3'h4, 3'h0, 1'h0, 8'h00, 1'h0, 1'h1},
         '{3'h4, 3'h4, 1'h0, 8'h00, 1'h0, 1'h0}, '{3'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
         '{3'h3, 3'h2, 1'h0, 8'h00, 1'h0, 1'h1}, '{3'h4, 3'h2, 1'h0, 8'h00, 1'h0, 1'h0},
         '{3'h4, 3'h1, 1'h0, 8'h00, 1'h0, 1'h1}, '{3'h0, 3'h0, 1'h1, 8'h01, 1'h0, 1'h1},
         '{3'h0, 3'h0, 1'h1, 8'h01, 1'h1, 1'h0}, '{3'h0, 3'h0, 1'h1, 8'h00, 1'h0, 1'h0},
         '{3'h1, 3'h0, 1'h1, 8'h02, 1'h0, 1'h1}, '{3'h0, 3'h0, 1'h1, 8'h02, 1'h0, 1'h0},
         '{3'h1, 3'h0, 1'h1, 8'h02, 1'h1, 1'h0}, '{3'h2, 3'h0, 1'h1, 8'h04, 1'h1, 1'h1},
         '{3'h0, 3'h0, 1'h1, 8'h08, 1'h0, 1'h1}, '{3'h0, 3'h0, 1'h1, 8'h08, 1'h1, 1'h0},
         '{3'h4, 3'h4, 1'h1, 8'h01, 1'h0, 1'h0}};
      repeat (2) @(posedge clk);
      cmp({rx_ready, ana_valid, window_tick, gps_avail, frame_present}, 5'h00);
      @(posedge clk);
      sys_rst <= 1'h0;
      repeat (2) @(posedge clk);
      $display("reset test done");
      for (int i = 0; i < 17; i++) run_row(i);
      repeat (2 * WIN + 10) @(posedge clk);
      cmp({frame_present, mpls_seen, vlan_seen}, 3'h0);
      $display("idle flag test done");
      meas_start <= 1'h1;
      @(posedge clk);
      meas_start <= 1'h0;
      wait_tick();
      e32 = 32'h0 - nominal_rate;
      cmp(rate_diff, e32);
      cmp(acc_diff, {{16{e32[31]}}, e32});
      build(3'h0, 30);
      src.send(30);
      wait_tick();
      e32 = 32'(8 * 30) - nominal_rate;
      ea = 48'(8 * 30) - 48'(nominal_rate) - 48'(nominal_rate);
      cmp(bit_rate, 32'(8 * 30));
      cmp(rate_diff, e32);
      cmp(acc_diff, ea);
      $display("rate test done");
      gps_present <= 1'h1;
      for (int k = 0; k < 29; k++) wait_tick();
      cmp(c, WIN);
      repeat (2) @(posedge clk);
      cmp(gps_avail, 1'h0);
      wait_tick();
      repeat (2) @(posedge clk);
      cmp(gps_avail, 1'h1);
      gps_present <= 1'h0;
      repeat (6) @(posedge clk);
      cmp(gps_avail, 1'h0);
      $display("gps test done");
      xre[0] <= 1'h1;
      wait_tick();
      wait_tick();
      cmp(c, 5 * 8);
      xre[0] <= 1'h0;
      $display("reference test done");
      got_q.delete();
      ana_ready <= 1'h0;
      filt_en <= 1'h0;
      {enc_eth, enc_snap, enc_llc} <= 3'h0;
      for (int j = 0; j < 9; j++) begin
         @(posedge clk);
         build(3'h0, 20 + j);
         src.send(20 + j);
      end
      repeat (5) @(posedge clk);
      cmp({rx_ready, ana_valid, ana_len}, {2'h1, 16'h0014});
      ana_ready <= 1'h1;
      repeat (20) @(posedge clk);
      cmp(got_q.size(), 9);
      foreach (got_q[j]) cmp(got_q[j], 20 + j);
      $display("buffer test done");
      meas_start <= 1'h1;
      @(posedge clk);
      meas_start <= 1'h0;
      @(posedge clk);
      cmp(acc_diff, 48'h0);
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      cmp({rx_ready, ana_valid, window_tick, frame_present}, 4'h0);
      sys_rst <= 1'h0;
      repeat (3) @(posedge clk);
      $display("second reset test done");
      tally_and_finish();
   end
   initial begin
      #2000000;
      mismatches++;
      tally_and_finish();
   end
endmodule // tb_top
